// >>> rtl/flash_seq_ctrl.sv
// Flash host sequencer: program, erase, suspend, clear, array read via APB.
// Assumes flash pins wired directly and the APB master on pclk.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_seq_ctrl (
    // Clock, reset, enable
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      en,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Flash pins
    output flash_seq_pkg::flash_pins_t     fl_pins,
    output logic                           fl_rp_n,
    input  wire logic [15:0]               fl_dq_i
);

    flash_seq_pkg::ctl_state_t q, d;
    logic                      cyc_done;
    logic [15:0]               cyc_rdata;
    logic                      busy;

    function automatic flash_seq_pkg::cyc_req_t mk_req(input logic wr, input logic [17:0] a, input logic [15:0] v);
        flash_seq_pkg::cyc_req_t r;
        r.start = 1'b1;
        r.wr    = wr;
        r.addr  = a;
        r.data  = v;
        return r;
    endfunction

    function automatic logic [15:0] cmd_for(input logic [2:0] op);
        case (op)
            `OP_PROGRAM: return `CMD_PROGRAM;
            `OP_ERASE:   return `CMD_ERASE_SETUP;
            `OP_CLEAR:   return `CMD_CLEAR;
            `OP_RESUME:  return `CMD_CONFIRM;
            default:     return `CMD_READ_ARRAY;
        endcase
    endfunction

    function automatic logic is_pe(input logic [2:0] op);
        return (op == `OP_PROGRAM) || (op == `OP_ERASE);
    endfunction

    assign busy = (q.st != flash_seq_pkg::S_IDLE) || q.go;

    always_comb
    begin
        d           = q;
        d.req.start = 1'b0;
        case (q.st)
            flash_seq_pkg::S_RST:
            begin
                d.rp_n = 1'b0;
                d.cnt  = q.cnt + `CNT_ONE;
                if (q.cnt == `CYC_RP - `CNT_ONE)
                begin
                    d.rp_n = 1'b1;
                    d.cnt  = '0;
                    d.st   = flash_seq_pkg::S_RWAIT;
                end
            end
            flash_seq_pkg::S_RWAIT:
            begin
                // Flash comes out of reset in array mode with a clean status
                d.cnt = q.cnt + `CNT_ONE;
                if (q.cnt == `CYC_RS - `CNT_ONE)
                begin
                    d.array_mode = 1'b1;
                    d.status     = '0;
                    d.st         = flash_seq_pkg::S_IDLE;
                end
            end
            flash_seq_pkg::S_IDLE:
            begin
                if (q.go)
                begin
                    d.go = 1'b0;
                    if (is_pe(q.op) && q.blocked)
                    begin
                        d.refused = 1'b1;                                       // [RL10] [RL15]
                    end
                    else if ((q.op == `OP_READ) && q.array_mode)
                    begin
                        d.refused = 1'b0;
                        d.st      = flash_seq_pkg::S_RD;
                    end
                    else if (is_pe(q.op) || (q.op == `OP_CLEAR) || (q.op == `OP_READ) ||
                             ((q.op == `OP_RESUME) && q.status[`SR_SUSP]))
                    begin
                        d.refused = 1'b0;
                        d.st      = flash_seq_pkg::S_SETUP;
                    end
                end
            end
            flash_seq_pkg::S_SETUP:
            begin
                if (!q.issued)
                begin
                    d.req    = mk_req(1'b1, q.addr, cmd_for(q.op));             // [RL11]
                    d.issued = 1'b1;
                end
                else if (cyc_done)
                begin
                    d.issued     = 1'b0;
                    d.array_mode = (q.op == `OP_READ);                           // [RL3] [RL9]
                    case (q.op)
                        `OP_PROGRAM, `OP_ERASE: d.st = flash_seq_pkg::S_DATA;
                        `OP_READ:               d.st = flash_seq_pkg::S_RD;
                        `OP_RESUME:             d.st = flash_seq_pkg::S_POLL;
                        default:
                        begin
                            d.status[`SR_ERR_HI:`SR_ERR_LO] = '0;                // [RL5]
                            d.blocked = 1'b0;                                   // [RL5] [RL10]
                            d.st      = flash_seq_pkg::S_DONE;
                        end
                    endcase
                end
            end
            flash_seq_pkg::S_DATA:
            begin
                if (!q.issued)
                begin
                    d.req    = mk_req(1'b1, q.addr, (q.op == `OP_ERASE) ? `CMD_CONFIRM : q.wdata); // [RL11]
                    d.issued = 1'b1;
                end
                else if (cyc_done)
                begin
                    d.issued = 1'b0;
                    d.st     = flash_seq_pkg::S_POLL;
                end
            end
            flash_seq_pkg::S_POLL:
            begin
                if (!q.issued)
                begin
                    d.req    = mk_req(1'b0, q.addr, '0);
                    d.issued = 1'b1;
                end
                else if (cyc_done)
                begin
                    d.issued = 1'b0;
                    d.status = cyc_rdata[7:0];
                    if (cyc_rdata[`SR_READY])
                    begin
                        // Latched even if software never looks at the error bits
                        d.blocked = q.blocked | cyc_rdata[`SR_SUPPLY_ERR];      // [RL8] [RL10]
                        d.st      = flash_seq_pkg::S_DONE;
                    end
                    else if (q.susp_req)
                    begin
                        d.susp_req = 1'b0;                                      // [RL6]
                        d.st       = flash_seq_pkg::S_SUSP;
                    end
                end
            end
            flash_seq_pkg::S_SUSP:
            begin
                if (!q.issued)
                begin
                    d.req    = mk_req(1'b1, q.addr, `CMD_SUSPEND);
                    d.issued = 1'b1;
                end
                else if (cyc_done)
                begin
                    d.issued = 1'b0;
                    d.st     = flash_seq_pkg::S_POLL;
                end
            end
            flash_seq_pkg::S_RD:
            begin
                if (!q.issued)
                begin
                    d.req    = mk_req(1'b0, q.addr, '0);                        // [RL9]
                    d.issued = 1'b1;
                end
                else if (cyc_done)
                begin
                    d.issued = 1'b0;
                    d.rdata  = cyc_rdata;
                    d.st     = flash_seq_pkg::S_DONE;
                end
            end
            flash_seq_pkg::S_DONE:
            begin
                d.st = flash_seq_pkg::S_IDLE;                                   // [RL1] [RL7]
            end
            default:
            begin
                d.st = flash_seq_pkg::S_RST;
            end
        endcase

        // APB: read data and error are decided in the setup cycle
        if (psel && !penable)
        begin
            d.slverr = 1'b0;
            d.prdata = '0;
            case (paddr)
                `REG_CTRL:   d.prdata = {29'h0, q.op};
                `REG_ADDR:   d.prdata = {14'h0, q.addr};
                `REG_WDATA:  d.prdata = {16'h0, q.wdata};
                `REG_STATUS: d.prdata = {20'h0, q.refused, q.blocked, q.array_mode, busy, q.status};
                `REG_RDATA:  d.prdata = {16'h0, q.rdata};
                default:     d.slverr = 1'b1;
            endcase
        end
        // Writes take effect at the access edge; a refusal set here beats any clear above
        if (psel && penable && pwrite)
        begin
            case (paddr)
                `REG_CTRL:
                begin
                    if (!busy)
                    begin
                        d.op = pwdata[2:0];
                        d.go = 1'b1;
                    end
                    else if ((pwdata[2:0] == `OP_SUSPEND) && (q.op == `OP_ERASE) && (q.st == flash_seq_pkg::S_POLL))
                    begin
                        d.susp_req = 1'b1;                                      // [RL6]
                    end
                    else
                    begin
                        d.refused = 1'b1;                                       // [RL15]
                    end
                end
                `REG_ADDR:  if (!busy) d.addr = pwdata[17:0];
                `REG_WDATA: if (!busy) d.wdata = pwdata[15:0];
                default:    d.go = d.go;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else if (en)
        begin
            q <= d;
        end
    end

    flash_bus_cycle cycle (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (en),
        .req     (q.req),
        .done    (cyc_done),
        .rdata   (cyc_rdata),
        .pins    (fl_pins),
        .dq_i    (fl_dq_i)
    );

    assign prdata  = q.prdata;
    assign pslverr = q.slverr;
    assign pready  = 1'b1;
    assign fl_rp_n = q.rp_n;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !en);

    chk_erase_confirm_follows: assert property ( // [RL11]
        (q.req.start && (q.st == flash_seq_pkg::S_SETUP) && (q.req.data == `CMD_ERASE_SETUP))
        |-> ##[1:40] (q.req.start && (q.req.data == `CMD_CONFIRM)))
        else $error("erase setup not followed by confirm");
    chk_blocked_no_start: assert property ( // [RL10]
        (q.req.start && (q.st == flash_seq_pkg::S_SETUP) && is_pe(q.op)) |-> !q.blocked)
        else $error("program or erase started while blocked");
    chk_clear_unblocks: assert property ( // [RL5]
        (q.req.start && (q.st == flash_seq_pkg::S_SETUP) && (q.req.data == `CMD_CLEAR)) |-> ##[1:40]
        ((q.st == flash_seq_pkg::S_DONE) && !q.blocked && (q.status[`SR_ERR_HI:`SR_ERR_LO] == 3'h0)))
        else $error("clear status did not clear errors");
    chk_status_mode_after: assert property ( // [RL3]
        ((q.st == flash_seq_pkg::S_DONE) && ($past(q.st) == flash_seq_pkg::S_POLL)) |-> !q.array_mode)
        else $error("array mode assumed after program or erase");
    chk_read_needs_array: assert property ( // [RL9]
        ((q.st == flash_seq_pkg::S_RD) && q.req.start) |-> q.array_mode)
        else $error("array read without read-array command");
    chk_poll_repeats: assert property ( // [RL6]
        ((q.st == flash_seq_pkg::S_POLL) && cyc_done && !cyc_rdata[`SR_READY] && !q.susp_req)
        |=> (q.st == flash_seq_pkg::S_POLL) ##1 q.req.start)
        else $error("polling stopped before ready");
    chk_refuse_when_blocked: assert property ( // [RL15]
        ((q.st == flash_seq_pkg::S_IDLE) && q.go && q.blocked && is_pe(q.op))
        |=> (q.refused && (q.st == flash_seq_pkg::S_IDLE)))
        else $error("blocked request not refused");
    chk_supply_latches: assert property ( // [RL8]
        ((q.st == flash_seq_pkg::S_POLL) && cyc_done && cyc_rdata[`SR_READY] && cyc_rdata[`SR_SUPPLY_ERR])
        |=> q.blocked [*2])
        else $error("supply error not latched");
    chk_back_to_back: assert property ( // [RL1] [RL7]
        (q.st == flash_seq_pkg::S_DONE) |=> ((q.st == flash_seq_pkg::S_IDLE) && !busy))
        else $error("sequencer not ready for next operation");

    cov_program_done: cover property ((q.st == flash_seq_pkg::S_DONE) && (q.op == `OP_PROGRAM));
    cov_erase_done: cover property ((q.st == flash_seq_pkg::S_DONE) && (q.op == `OP_ERASE));
    cov_suspend: cover property (q.req.start && (q.req.data == `CMD_SUSPEND));
    cov_refused: cover property ($rose(q.refused) && q.blocked);

endmodule

// >>> rtl/flash_seq_params.svh
// Sequencer constants: command codes, status bits, offsets, pin timing.
// Assumes a command-driven asynchronous flash and a 200 MHz pclk.
//
// Summary of operation
// (RL1) Programs may run back to back.
// (RL2) Device refuses programs while supply error set.
// (RL3) After program, send FFh before array reads.
// (RL4) Device refuses erases while supply error set.
// (RL5) Error bits 3-5 cleared only by clear-status.
// (RL6) Poll erase until ready; may suspend meanwhile.
// (RL7) Erases may run back to back.
// (RL8) Error check optional; supply error still blocks.
// (RL9) After erase, send FFh before array reads.
// (RL10) Supply error blocks program/erase until clear-status.
// (RL11) Erase is 20h then D0h at block address.
// (RL12) Busy device returns status on every read.
// (RL13) Bad erase confirm sets bits 4 and 5.
// (RL14) Reset clears status and selects array read.
// (RL15) Finish, check, clear before next program/erase. Code refuses program/erase only while busy or while a supply error is latched.
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

`define CLK_MHZ          200
`define NS2CYC(ns)       ((((ns) * `CLK_MHZ) + 999) / 1000)
`define T_WP_NS          50
`define T_WPH_NS         30
`define T_ACC_NS         80
`define T_RP_NS          60
`define T_RS_NS          1000
`define SYNC_STAGES      3
`define CYC_WP           8'(`NS2CYC(`T_WP_NS))
`define CYC_WPH          8'(`NS2CYC(`T_WPH_NS))
`define CYC_RD           8'(`NS2CYC(`T_ACC_NS) + `SYNC_STAGES)
`define CYC_RP           8'(`NS2CYC(`T_RP_NS))
`define CYC_RS           8'(`NS2CYC(`T_RS_NS))
`define CNT_ONE          8'h01

`define CMD_READ_ARRAY   16'h00FF
`define CMD_CLEAR        16'h0050
`define CMD_ERASE_SETUP  16'h0020
`define CMD_CONFIRM      16'h00D0
`define CMD_PROGRAM      16'h0040
`define CMD_SUSPEND      16'h00B0

`define SR_READY         7
`define SR_SUSP          6
`define SR_ERR_HI        5
`define SR_ERR_LO        3
`define SR_SUPPLY_ERR    3

`define OP_PROGRAM       3'h1
`define OP_ERASE         3'h2
`define OP_CLEAR         3'h3
`define OP_READ          3'h4
`define OP_SUSPEND       3'h5
`define OP_RESUME        3'h6

`define REG_CTRL         12'h000
`define REG_ADDR         12'h004
`define REG_WDATA        12'h008
`define REG_STATUS       12'h00C
`define REG_RDATA        12'h010

`endif

// >>> rtl/flash_seq_pkg.sv
// Types shared by the flash sequencer and its pin cycle engine.
// Assumes the constants header for widths of the command fields.
package flash_seq_pkg;

    typedef struct packed {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [17:0] addr;
        logic [15:0] dq_o;
        logic        dq_oe_n;
    } flash_pins_t;

    typedef struct packed {
        logic        start;
        logic        wr;
        logic [17:0] addr;
        logic [15:0] data;
    } cyc_req_t;

    typedef enum logic [2:0] {C_IDLE, C_SETUP, C_LOW, C_HIGH, C_READ} cyc_st_t;

    typedef struct packed {
        cyc_st_t     st;
        logic [7:0]  cnt;
        logic        done;
        logic [15:0] rdata;
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        flash_pins_t pins;
    } cyc_state_t;

    typedef enum logic [3:0] {S_RST, S_RWAIT, S_IDLE, S_SETUP, S_DATA, S_POLL, S_SUSP, S_RD, S_DONE} ctl_st_t;

    typedef struct packed {
        ctl_st_t     st;
        logic        issued;
        logic [7:0]  cnt;
        logic [2:0]  op;
        logic        go;
        logic [17:0] addr;
        logic [15:0] wdata;
        logic [7:0]  status;
        logic [15:0] rdata;
        logic        array_mode;
        logic        blocked;
        logic        refused;
        logic        susp_req;
        logic        rp_n;
        cyc_req_t    req;
        logic [31:0] prdata;
        logic        slverr;
    } ctl_state_t;

endpackage

// >>> rtl/flash_bus_cycle.sv
// One flash bus cycle, write or read, timed in pclk cycles.
// Assumes one request at a time; data pins pass three flops.
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_bus_cycle (
    // Clock, reset, enable
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      en,
    // Request and answer
    input  wire flash_seq_pkg::cyc_req_t   req,
    output logic                           done,
    output logic [15:0]                    rdata,
    // Flash pins
    output flash_seq_pkg::flash_pins_t     pins,
    input  wire logic [15:0]               dq_i
);

    flash_seq_pkg::cyc_state_t q, d;

    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        d.s1   = dq_i;
        d.s2   = q.s1;
        d.s3   = q.s2;
        case (q.st)
            flash_seq_pkg::C_IDLE:
            begin
                d.pins.ce_n    = 1'b1;
                d.pins.we_n    = 1'b1;
                d.pins.oe_n    = 1'b1;
                d.pins.dq_oe_n = 1'b1;
                if (req.start)
                begin
                    d.pins.addr = req.addr;
                    d.pins.ce_n = 1'b0;
                    d.cnt       = '0;
                    if (req.wr)
                    begin
                        d.pins.dq_o    = req.data;
                        d.pins.dq_oe_n = 1'b0;
                        d.st           = flash_seq_pkg::C_SETUP;
                    end
                    else
                    begin
                        d.pins.oe_n = 1'b0;
                        d.st        = flash_seq_pkg::C_READ;
                    end
                end
            end
            flash_seq_pkg::C_SETUP:
            begin
                d.pins.we_n = 1'b0;
                d.st        = flash_seq_pkg::C_LOW;
            end
            flash_seq_pkg::C_LOW:
            begin
                // Pulse width also covers address and data setup to the rising edge
                d.cnt = q.cnt + `CNT_ONE;
                if (q.cnt == `CYC_WP - `CNT_ONE)
                begin
                    d.pins.we_n = 1'b1;
                    d.cnt       = '0;
                    d.st        = flash_seq_pkg::C_HIGH;
                end
            end
            flash_seq_pkg::C_HIGH:
            begin
                d.cnt = q.cnt + `CNT_ONE;
                if (q.cnt == `CYC_WPH - `CNT_ONE)
                begin
                    d.pins.ce_n    = 1'b1;
                    d.pins.dq_oe_n = 1'b1;
                    d.done         = 1'b1;
                    d.st           = flash_seq_pkg::C_IDLE;
                end
            end
            flash_seq_pkg::C_READ:
            begin
                if (q.cnt != `CYC_RD)
                begin
                    d.cnt = q.cnt + `CNT_ONE;
                end
                // Wait for a stable word so a bus still settling is not captured
                else if (q.s2 == q.s3)
                begin
                    d.rdata     = q.s3;
                    d.done      = 1'b1;
                    d.pins.ce_n = 1'b1;
                    d.pins.oe_n = 1'b1;
                    d.st        = flash_seq_pkg::C_IDLE;
                end
            end
            default:
            begin
                d.st = flash_seq_pkg::C_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.pins.ce_n    <= 1'b1;
            q.pins.we_n    <= 1'b1;
            q.pins.oe_n    <= 1'b1;
            q.pins.dq_oe_n <= 1'b1;
        end
        else if (en)
        begin
            q <= d;
        end
    end

    assign done  = q.done;
    assign rdata = q.rdata;
    assign pins  = q.pins;

endmodule

// >>> verif/flash_dev_model.sv
// Flash model: command decoder, status byte, sparse word array.
// Assumes controller pins; pclk paces the busy engine and the read data register.
`timescale 1ns/1ps

module flash_dev_model #(
    parameter int PROG_CYC  = 40,
    parameter int ERASE_CYC = 600
) (
    // Timing and supply
    input  wire logic                       pclk,
    input  wire logic                       rp_n,
    input  wire logic                       supply_bad,
    // Pins
    input  wire flash_seq_pkg::flash_pins_t pins,
    output logic [15:0]                     drv
);
    logic [15:0] mem [int];
    logic [15:0] val_q;
    logic [15:0] last_q;
    logic [7:0]  sr;
    logic        array_rd;
    logic        setup_pgm;
    logic        setup_ers;
    logic        susp;
    logic        rd;
    int          busy;

    assign rd  = !pins.ce_n && !pins.oe_n && rp_n;
    // Released bus shows the inverse of the last value, so stale data never matches
    assign drv = rd ? val_q : ~last_q;

    always @(posedge pclk)
    begin
        val_q <= array_rd ? (mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 16'hFFFF) : {8'h00, sr};
        if (rd)
            last_q <= val_q;
        if (busy > 0 && !susp)
        begin
            busy = busy - 1;
            if (busy == 0)
                sr[7] = 1'b1;
        end
    end

    always @(posedge pins.we_n or negedge rp_n)
    begin
        if (!rp_n)
        begin
            sr = 8'h80;
            {array_rd, setup_pgm, setup_ers, susp} = 4'b1000;
            busy = 0;
        end
        else if (!pins.ce_n && busy > 0 && !susp)
        begin
            // Only a suspend is heard while the engine runs
            if (pins.dq_o[7:0] == 8'hB0)
            begin
                susp = 1'b1;
                sr[7:6] = 2'b11;
            end
        end
        else if (!pins.ce_n && setup_pgm)
        begin
            setup_pgm = 1'b0;
            if (!sr[3] && supply_bad)
                sr[3] = 1'b1;
            else if (!sr[3])
            begin
                mem[int'(pins.addr)] = pins.dq_o;
                busy = PROG_CYC;
                sr[7] = 1'b0;
            end
        end
        else if (!pins.ce_n && setup_ers)
        begin
            setup_ers = 1'b0;
            if (pins.dq_o[7:0] != 8'hD0)
                sr[5:4] = 2'b11;
            else if (!sr[3] && supply_bad)
                sr[3] = 1'b1;
            else if (!sr[3])
            begin
                foreach (mem[k])
                    if (k[17:12] == int'(pins.addr[17:12]))
                        mem[k] = 16'hFFFF;
                busy = ERASE_CYC;
                sr[7] = 1'b0;
            end
        end
        else if (!pins.ce_n)
        begin
            array_rd  = (pins.dq_o[7:0] == 8'hFF);
            setup_pgm = (pins.dq_o[7:0] == 8'h40);
            setup_ers = (pins.dq_o[7:0] == 8'h20);
            if (pins.dq_o[7:0] == 8'h50)
                sr[5:3] = 3'b000;
            if (pins.dq_o[7:0] == 8'hD0 && susp)
            begin
                susp = 1'b0;
                sr[7:6] = 2'b00;
            end
        end
    end
endmodule

// >>> verif/flash_program_erase_status_flow_tb.sv
// Bench: APB master, flash model, reference array.
// Waits for pready, assumes no wait-state count.
`timescale 1ns/1ps
`include "flash_seq_params.svh"

module flash_program_erase_status_flow_tb;
    logic                       pclk;
    logic                       presetn;
    logic                       en;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [11:0]                paddr;
    logic [31:0]                pwdata;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    flash_seq_pkg::flash_pins_t fl_pins;
    logic                       fl_rp_n;
    logic                       supply_bad;
    logic [15:0]                fl_dq_i;
    logic [15:0]                drv;
    logic [31:0]                rd;
    logic                       err;
    logic [15:0]                ref_mem [int];
    logic [17:0]                q [$];
    int                         bad_count = 0;
    int                         checks = 0;
    int                         cycles = 0;
    int                         wcount = 0;

    assign fl_dq_i = (fl_pins.dq_oe_n == 1'b0) ? fl_pins.dq_o : drv;

    flash_seq_ctrl DUT (.*);
    flash_dev_model FLASH (.pclk(pclk), .rp_n(fl_rp_n), .supply_bad(supply_bad), .pins(fl_pins), .drv(drv));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(negedge fl_pins.we_n) wcount++;

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle();
        rd = 32'h0000_0100;
        for (int i = 0; i < 3000 && rd[8] !== 1'b0; i++) apb(1'b0, `REG_STATUS, 32'h0000_0000);
    endtask

    task automatic cst(input logic [11:0] e);
        check({20'h0_0000, rd[11:0]}, {20'h0_0000, e});
    endtask

    task automatic run(input logic [2:0] op, input logic [17:0] a, input logic [15:0] d);
        apb(1'b1, `REG_ADDR, {14'h0000, a});
        apb(1'b1, `REG_WDATA, {16'h0000, d});
        apb(1'b1, `REG_CTRL, {29'h0000_0000, op});
        repeat (4) @(posedge pclk);
        idle();
    endtask

    task automatic rdw(input logic [17:0] a);
        run(3'h4, a, 16'h0000);
        apb(1'b0, `REG_RDATA, 32'h0000_0000);
        check(rd, {16'h0000, ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 16'hFFFF});
    endtask

    initial
    begin
        {en, presetn, psel, penable, pwrite, supply_bad} = 6'b100000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        void'($urandom(72314));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        idle();
        rdw(18'h3_0010);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            q.push_back({6'(i + 1), 12'($urandom)});
            ref_mem[int'(q[i])] = 16'($urandom);
            run(3'h1, q[i], ref_mem[int'(q[i])]);
            cst(12'h080);
        end
        foreach (q[i]) rdw(q[i]);
        $display("test program done");
        for (int i = 0; i < 2; i++)
        begin
            run(3'h2, q[i], 16'h0000);
            cst(12'h080);
            ref_mem.delete(int'(q[i]));
        end
        foreach (q[i]) rdw(q[i]);
        $display("test erase done");
        supply_bad <= 1'b1;
        run(3'h1, 18'h0_0100, 16'h1234);
        cst(12'h488);
        supply_bad <= 1'b0;
        wcount = 0;
        run(3'h1, 18'h0_0100, 16'h1234);
        cst(12'hC88);
        run(3'h2, 18'h0_0100, 16'h0000);
        cst(12'hC88);
        check(wcount, 0);
        run(3'h3, 18'h0_0000, 16'h0000);
        cst(12'h080);
        ref_mem[int'(18'h0_0100)] = 16'h1234;
        run(3'h1, 18'h0_0100, 16'h1234);
        rdw(18'h0_0100);
        $display("test supply done");
        apb(1'b1, `REG_ADDR, {14'h0000, q[2]});
        apb(1'b1, `REG_CTRL, 32'h0000_0002);
        repeat (40) @(posedge pclk);
        en <= 1'b0;
        repeat (20) @(posedge pclk);
        en <= 1'b1;
        run(3'h5, q[2], 16'h0000);
        cst(12'h0C0);
        run(3'h6, q[2], 16'h0000);
        cst(12'h080);
        ref_mem.delete(int'(q[2]));
        rdw(q[2]);
        $display("test suspend done");
        apb(1'b0, 12'h020, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        $display("test unmapped done");
        end_of_test();
    end
endmodule
